// ==== rtl/oss_pkg.sv ====
// Purpose: shared constants and carrier types for the operand size and segment select decoder
// Assumes: one core clock, decode results registered once
// Notes: size codes are small enumerations, segment codes index the segment base table
package oss_pkg;
  // execution modes
  typedef enum logic [2:0] {
    OSS_MODE_REAL   = 3'h1,
    OSS_MODE_PROT   = 3'h2,
    OSS_MODE_LONG   = 3'h4
  } oss_mode_e;

  // effective sizes
  typedef enum logic [1:0] {
    OSS_SZ_16 = 2'h0,
    OSS_SZ_32 = 2'h1,
    OSS_SZ_64 = 2'h2
  } oss_size_e;

  // segment register codes, also the override prefix payload
  typedef enum logic [2:0] {
    OSS_SEG_EXTRA = 3'h0,
    OSS_SEG_CODE  = 3'h1,
    OSS_SEG_STACK = 3'h2,
    OSS_SEG_DATA  = 3'h3,
    OSS_SEG_AUXA  = 3'h4,
    OSS_SEG_AUXB  = 3'h5
  } oss_seg_e;

  // reference kinds
  typedef enum logic [2:0] {
    OSS_REF_FETCH = 3'h0,
    OSS_REF_PUSHPOP = 3'h1,
    OSS_REF_DATA  = 3'h2,
    OSS_REF_STRDST = 3'h3,
    OSS_REF_NONE  = 3'h4
  } oss_ref_e;

  // register extension prefix field positions (4-bit payload)
  localparam int unsigned REXT_W_BIT = 3;
  localparam int unsigned REXT_R_BIT = 2;
  localparam int unsigned REXT_X_BIT = 1;
  localparam int unsigned REXT_B_BIT = 0;

  // general register numbers with special meaning
  localparam logic [3:0] REG_ACC = 4'h0;
  localparam logic [3:0] REG_PAIR_HIGH = 4'h2;
  localparam logic [3:0] REG_STACK_PTR = 4'h4;
  localparam logic [3:0] REG_FRAME_PTR = 4'h5;

  // arithmetic op classes
  localparam logic [3:0] OP_UDIV = 4'hE;
  localparam logic [3:0] OP_SDIV = 4'hF;

  // immediate limit: largest unsigned doubleword
  localparam logic [63:0] IMM_LIMIT = 64'h0000_0000_FFFF_FFFF;

  // reset values of outputs
  localparam logic [1:0] RST_SIZE = 2'h1;
  localparam logic [2:0] RST_SEG = 3'h3;

  // one instruction's prefix and operand summary
  typedef struct packed {
    logic       valid;
    logic       opsize_pfx;    // operand-size override byte present
    logic       adsize_pfx;    // address-size override byte present
    logic       rext_pfx;      // register extension prefix present
    logic [3:0] rext_bits;     // its 4-bit payload
    logic       vec_mandatory; // override byte used as vector opcode extension
    logic       seg_ovr;       // segment override prefix present
    oss_seg_e seg_ovr_sel;
    oss_ref_e ref_kind;
    logic       base_used;
    logic [3:0] base_reg;
    logic       byte_reg;      // operand is a byte register
    logic [3:0] byte_reg_num;
    logic [3:0] arith_op;
    logic       is_arith;
    logic       imm_present;
    logic [63:0] imm_value;
  } oss_instr_s;

  // mode state
  typedef struct packed {
    oss_mode_e  mode;
    logic       cs_long;   // long-mode flag of the code segment descriptor
    logic       cs_dflag;  // default-size flag of the code segment descriptor
  } oss_modest_s;

  // decode result
  typedef struct packed {
    oss_size_e op_size;
    oss_size_e ad_size;
    oss_seg_e seg;
    logic       seg_base_zero;
    logic       imm_ok;
    logic       byte_reg_ok;
    logic       byte_high;   // byte register maps to the legacy high byte
  } oss_result_s;
endpackage

// ==== rtl/oss_seg_sel.sv ====
// Purpose: default segment choice and override filtering
// Assumes: combinational, one memory reference per instruction
// Notes: the auxiliary segments keep their base in 64-bit mode
`timescale 1ns/1ps
module oss_seg_sel (
  input wire oss_pkg::oss_instr_s instr_in,   // current instruction
  input wire logic sixty_four_in,             // 64-bit mode active
  output oss_pkg::oss_seg_e seg_out,          // segment used
  output logic base_zero_out                  // segment base forced to zero
);
  oss_pkg::oss_seg_e dflt;
  logic stack_base;

  assign stack_base = instr_in.base_used &
                      (instr_in.base_reg == oss_pkg::REG_STACK_PTR ||
                       instr_in.base_reg == oss_pkg::REG_FRAME_PTR);

  // default segment by reference type
  always_comb begin
    unique case (instr_in.ref_kind)
      oss_pkg::OSS_REF_FETCH: dflt = oss_pkg::OSS_SEG_CODE;
      oss_pkg::OSS_REF_PUSHPOP: dflt = oss_pkg::OSS_SEG_STACK;
      oss_pkg::OSS_REF_STRDST: dflt = oss_pkg::OSS_SEG_EXTRA;
      default: dflt = stack_base ? oss_pkg::OSS_SEG_STACK : oss_pkg::OSS_SEG_DATA;
    endcase
  end

  // overrides only touch plain data references
  always_comb begin
    seg_out = dflt;
    if (instr_in.seg_ovr && instr_in.ref_kind == oss_pkg::OSS_REF_DATA) begin
      seg_out = instr_in.seg_ovr_sel;
    end
  end

  // flat model in 64-bit mode apart from the two auxiliary segments
  assign base_zero_out = sixty_four_in &
                         (seg_out != oss_pkg::OSS_SEG_AUXA) &
                         (seg_out != oss_pkg::OSS_SEG_AUXB);
endmodule // oss_seg_sel

// ==== rtl/oss_size_dec.sv ====
// Purpose: effective operand and address size from mode and prefixes
// Assumes: purely combinational, inputs stable within the cycle
// Notes: per-instruction only; nothing here holds state between instructions
`timescale 1ns/1ps
module oss_size_dec (
  input wire oss_pkg::oss_instr_s instr_in,    // current instruction
  input wire oss_pkg::oss_modest_s modest_in,  // mode state
  output oss_pkg::oss_size_e op_size_out,      // effective operand size
  output oss_pkg::oss_size_e ad_size_out       // effective address size
);
  logic wide_operand_bit;
  logic sixty_four;
  logic opsz_eff;

  // vector mandatory bytes never count as operand-size override
  assign opsz_eff = instr_in.opsize_pfx & ~instr_in.vec_mandatory;
  assign wide_operand_bit = instr_in.rext_pfx &
                            instr_in.rext_bits[oss_pkg::REXT_W_BIT];
  assign sixty_four = (modest_in.mode == oss_pkg::OSS_MODE_LONG) & modest_in.cs_long;

  // size table, fresh per instruction so overrides never linger
  always_comb begin
    op_size_out = oss_pkg::OSS_SZ_16;
    ad_size_out = oss_pkg::OSS_SZ_16;
    if (sixty_four) begin
      if (wide_operand_bit) begin
        op_size_out = oss_pkg::OSS_SZ_64;
      end else if (opsz_eff) begin
        op_size_out = oss_pkg::OSS_SZ_16;
      end else begin
        op_size_out = oss_pkg::OSS_SZ_32;
      end
      // never 16-bit addressing here
      ad_size_out = instr_in.adsize_pfx ? oss_pkg::OSS_SZ_32 : oss_pkg::OSS_SZ_64;
    end else begin
      // legacy and compatibility: default flag toggled by each override byte
      if (modest_in.mode != oss_pkg::OSS_MODE_REAL && modest_in.cs_dflag) begin
        op_size_out = opsz_eff ? oss_pkg::OSS_SZ_16 : oss_pkg::OSS_SZ_32;
        ad_size_out = instr_in.adsize_pfx ? oss_pkg::OSS_SZ_16 : oss_pkg::OSS_SZ_32;
      end else begin
        op_size_out = opsz_eff ? oss_pkg::OSS_SZ_32 : oss_pkg::OSS_SZ_16;
        ad_size_out = instr_in.adsize_pfx ? oss_pkg::OSS_SZ_32 : oss_pkg::OSS_SZ_16;
      end
    end
  end
endmodule // oss_size_dec

// ==== rtl/oss_top.sv ====
// Purpose: operand size and segment select decoder for the core front end
// Assumes: instruction summary arrives pre-parsed, one per cycle when valid
// Notes: all results registered; one cycle from valid input to valid output
//
// Summary of operation
// - 64-bit mode with no prefix: 64-bit address, 32-bit operand.
// - 64-bit mode never gives 16-bit addressing; override gives 32.
// - in 64-bit mode, wide operand bit forces a 64-bit operand.
// - wide operand bit beats the operand-size override byte.
// - 64-bit mode override byte alone gives a 16-bit operand.
// - address override in 64-bit mode gives 32-bit addressing, per instruction.
// - 64-bit table only when code segment long flag is set.
// - vector mandatory extension bytes do not interact with wide bit.
// - extension prefix holds a 4-bit field, one bit is wide operand.
// - arithmetic except divides accept immediates up to doubleword limit.
// - register pair: first register high half, second low half.
// - stack segment for push, pop and stack or frame pointer base.
// - fetch uses code, data uses data, string destination uses extra.
// - segment override prefix replaces the default data segment.
// - overrides ignored for fetch, string destination and push or pop.
// - explicit selector is 16 bits from memory or register.
// - far pointer: offset from first doubleword, selector from next word.
// - offsets are 16 or 32 bits legacy, up to 64 in 64-bit mode.
// - compatibility mode segments behave as legacy protected mode.
// - 64-bit mode code, data, extra, stack bases read as zero.
// - 64-bit mode auxiliary segments keep their base.
// - new low byte regs need the prefix; high byte regs need none.
// - overrides affect only their own instruction.
`timescale 1ns/1ps
module oss_top #(
  parameter int unsigned ADDR_W = 64  // linear address width
) (
  input wire logic CLK_SYS_IN,                       // 20 MHz core clock
  input wire logic NRST_IN,                          // async reset, active low
  input wire oss_pkg::oss_instr_s INSTR_IN,          // parsed instruction
  input wire oss_pkg::oss_modest_s MODE_IN,          // execution mode state
  input wire logic [ADDR_W-1:0] EADDR_IN,            // effective address
  input wire logic [ADDR_W-1:0] SEG_BASE_IN [6],     // segment bases by code
  input wire logic [63:0] PAIR_HIGH_IN,              // first register of a pair
  input wire logic [63:0] PAIR_LOW_IN,               // second register of a pair
  input wire logic [47:0] FAR_PTR_IN,                // far pointer bytes from memory
  input wire logic SEL_FROM_MEM_IN,                  // explicit selector source is memory
  input wire logic [15:0] SEL_MEM_IN,                // selector word from memory
  input wire logic [15:0] SEL_REG_IN,                // selector from 16-bit register
  output logic VALID_OUT,                            // result valid
  output oss_pkg::oss_result_s RESULT_OUT,           // sizes and segment
  output logic [ADDR_W-1:0] LADDR_OUT,               // linear address
  output logic [127:0] PAIR_OUT,                     // combined register pair
  output logic [31:0] FAR_OFS_OUT,                   // far pointer offset
  output logic [15:0] FAR_SEL_OUT,                   // far pointer selector
  output logic [15:0] SEL_OUT                        // explicit selector
);
  oss_pkg::oss_size_e op_size;
  oss_pkg::oss_size_e ad_size;
  oss_pkg::oss_seg_e seg;
  logic base_zero;
  logic sixty_four;
  logic imm_ok;
  logic byte_ok;
  logic byte_high;
  logic [ADDR_W-1:0] eaddr_cut;
  logic [ADDR_W-1:0] base_sel;

  // mask an address to the effective address size
  function automatic logic [ADDR_W-1:0] addr_mask(input logic [ADDR_W-1:0] a,
                                                  input oss_pkg::oss_size_e s);
    logic [ADDR_W-1:0] r;
    r = a;
    if (s == oss_pkg::OSS_SZ_16) begin
      r = {{(ADDR_W-16){1'b0}}, a[15:0]};
    end else if (s == oss_pkg::OSS_SZ_32) begin
      r = {{(ADDR_W-32){1'b0}}, a[31:0]};
    end
    return r;
  endfunction

  assign sixty_four = (MODE_IN.mode == oss_pkg::OSS_MODE_LONG) & MODE_IN.cs_long;

  oss_size_dec u_size (
    .instr_in(INSTR_IN),
    .modest_in(MODE_IN),
    .op_size_out(op_size),
    .ad_size_out(ad_size)
  );

  oss_seg_sel u_seg (
    .instr_in(INSTR_IN),
    .sixty_four_in(sixty_four),
    .seg_out(seg),
    .base_zero_out(base_zero)
  );

  // immediates: divides refused, magnitude capped at the doubleword limit
  always_comb begin
    imm_ok = 1'b1;
    if (INSTR_IN.is_arith && INSTR_IN.imm_present) begin
      imm_ok = (INSTR_IN.arith_op != oss_pkg::OP_UDIV) &&
               (INSTR_IN.arith_op != oss_pkg::OP_SDIV) &&
               (INSTR_IN.imm_value <= oss_pkg::IMM_LIMIT);
    end
  end

  // byte register legality: numbers 4..7 change meaning with the prefix
  always_comb begin
    byte_ok = 1'b1;
    byte_high = 1'b0;
    if (INSTR_IN.byte_reg) begin
      if (INSTR_IN.rext_pfx) begin
        byte_ok = 1'b1; // low bytes of index, pointer and upper regs
      end else begin
        byte_ok = (INSTR_IN.byte_reg_num < 4'h8); // upper regs need the prefix
        byte_high = (INSTR_IN.byte_reg_num >= oss_pkg::REG_STACK_PTR) &&
                    (INSTR_IN.byte_reg_num < 4'h8);
      end
    end
  end

  // linear address: base suppressed in the flat model, offset cut to size
  assign eaddr_cut = addr_mask(EADDR_IN, ad_size);
  assign base_sel = base_zero ? '0 : SEG_BASE_IN[seg];

  // valid pipeline; nothing of the prefixes is kept past this stage
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      VALID_OUT <= 1'b0;
    end else begin
      VALID_OUT <= INSTR_IN.valid;
    end
  end

  // decode result register, reloaded every instruction
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      RESULT_OUT <= '{op_size: oss_pkg::oss_size_e'(oss_pkg::RST_SIZE),
                      ad_size: oss_pkg::oss_size_e'(oss_pkg::RST_SIZE),
                      seg: oss_pkg::oss_seg_e'(oss_pkg::RST_SEG),
                      seg_base_zero: 1'b0, imm_ok: 1'b1,
                      byte_reg_ok: 1'b1, byte_high: 1'b0};
      LADDR_OUT <= '0;
    end else if (INSTR_IN.valid) begin
      RESULT_OUT <= '{op_size: op_size, ad_size: ad_size, seg: seg,
                      seg_base_zero: base_zero, imm_ok: imm_ok,
                      byte_reg_ok: byte_ok, byte_high: byte_high};
      LADDR_OUT <= addr_mask(base_sel + eaddr_cut,
                             sixty_four ? oss_pkg::OSS_SZ_64 : oss_pkg::OSS_SZ_32);
    end
  end

  // register pair join: first-named register is the high half
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      PAIR_OUT <= '0;
    end else begin
      PAIR_OUT <= {PAIR_HIGH_IN, PAIR_LOW_IN};
    end
  end

  // far pointer split: low doubleword offset, following word selector
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      FAR_OFS_OUT <= '0;
      FAR_SEL_OUT <= '0;
    end else begin
      FAR_OFS_OUT <= FAR_PTR_IN[31:0];
      FAR_SEL_OUT <= FAR_PTR_IN[47:32];
    end
  end

  // explicit selector, always 16 bits wide whatever the operand size
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      SEL_OUT <= '0;
    end else begin
      SEL_OUT <= SEL_FROM_MEM_IN ? SEL_MEM_IN : SEL_REG_IN;
    end
  end
endmodule // oss_top

// ==== tb/operand_size_segment_select_bench.sv ====
// Purpose: self-checking bench for the operand size and segment select decoder
// Assumes: one result one cycle after each valid instruction
// Notes: expected results come from a reference decode written here
`timescale 1ns/1ps
module operand_size_segment_select_bench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  oss_pkg::oss_instr_s instr = '0;
  oss_pkg::oss_modest_s mode = '0;
  logic [63:0] eaddr = '0;
  logic [63:0] bases [6] = '{default: '0};
  logic [63:0] ph = '0;
  logic [63:0] pl = '0;
  logic [47:0] far = '0;
  logic sfm = 1'b0;
  logic [15:0] sm = '0;
  logic [15:0] sr = '0;
  logic vld;
  oss_pkg::oss_result_s res;
  logic [63:0] la;
  logic [74:0] exp_q [$];
  int mismatches = 0;
  int samples_checked = 0;

  oss_top #(.ADDR_W(64)) dut_u (.CLK_SYS_IN(clk_sys), .NRST_IN(nrst), .INSTR_IN(instr),
    .MODE_IN(mode), .EADDR_IN(eaddr), .SEG_BASE_IN(bases), .PAIR_HIGH_IN(ph),
    .PAIR_LOW_IN(pl), .FAR_PTR_IN(far), .SEL_FROM_MEM_IN(sfm), .SEL_MEM_IN(sm),
    .SEL_REG_IN(sr), .VALID_OUT(vld), .RESULT_OUT(res), .LADDR_OUT(la), .PAIR_OUT(),
    .FAR_OFS_OUT(), .FAR_SEL_OUT(), .SEL_OUT());

  // 20 MHz clock
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [74:0] seen, input logic [74:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task automatic end_sim();
    $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // reference decode: {op, ad, seg, base_zero, imm_ok, byte_ok, byte_high, linear address}
  function automatic logic [74:0] model(oss_pkg::oss_instr_s i, oss_pkg::oss_modest_s m);
    logic l64;
    logic [1:0] dflt;
    logic [1:0] op;
    logic [1:0] ad;
    logic [2:0] sg;
    logic [63:0] a;
    l64 = m.mode == oss_pkg::OSS_MODE_LONG && m.cs_long;
    dflt = (m.mode != oss_pkg::OSS_MODE_REAL && m.cs_dflag) ? 2'h1 : 2'h0;
    if (l64) begin
      op = i.rext_pfx && i.rext_bits[3] ? 2'h2 : i.opsize_pfx && !i.vec_mandatory ? 2'h0 : 2'h1;
      ad = i.adsize_pfx ? 2'h1 : 2'h2;
    end else begin
      op = dflt ^ 2'(i.opsize_pfx && !i.vec_mandatory);
      ad = dflt ^ 2'(i.adsize_pfx);
    end
    case (i.ref_kind)
      oss_pkg::OSS_REF_FETCH: sg = 3'h1;
      oss_pkg::OSS_REF_PUSHPOP: sg = 3'h2;
      oss_pkg::OSS_REF_STRDST: sg = 3'h0;
      default: sg = i.seg_ovr ? i.seg_ovr_sel : (i.base_used && i.base_reg inside {4'h4, 4'h5})
        ? 3'h2 : 3'h3;
    endcase
    // the offset is cut to the address size before any base is added
    a = ad == 2'h0 ? {48'h0, eaddr[15:0]} : ad == 2'h1 ? {32'h0, eaddr[31:0]} : eaddr;
    a = (l64 && !sg[2]) ? a : bases[sg] + a;
    if (!l64) a = {32'h0, a[31:0]};
    return {op, ad, sg, l64 && !sg[2], !(i.is_arith && i.imm_present) || (i.arith_op < 4'hE
      && i.imm_value <= 64'h0000_0000_FFFF_FFFF), !i.byte_reg || i.rext_pfx
      || !i.byte_reg_num[3], i.byte_reg && !i.rext_pfx && i.byte_reg_num[3:2] == 2'h1, a};
  endfunction

  task automatic send(input oss_pkg::oss_instr_s i, input oss_pkg::oss_modest_s m);
    @(posedge clk_sys);
    #2;
    eaddr = {$urandom, $urandom};
    instr = i;
    mode = m;
    if (i.valid) exp_q.push_back(model(i, m));
  endtask

  // bounded wait until every note has been matched
  task automatic drain();
    @(posedge clk_sys);
    #2;
    instr.valid = 1'b0;
    for (int n = 0; n < 10 && exp_q.size() > 0; n++) @(posedge clk_sys);
    if (exp_q.size() > 0) begin
      mismatches++;
      end_sim();
    end
  endtask

  // back-to-back tables; alternating prefixes also show overrides do not linger
  task automatic directed(input int t);
    oss_pkg::oss_instr_s i;
    oss_pkg::oss_modest_s m;
    for (int k = 0; k < 32; k++) begin
      i = '0;
      m = '0;
      i.valid = 1'b1;
      i.ref_kind = oss_pkg::OSS_REF_DATA;
      m.mode = oss_pkg::OSS_MODE_LONG;
      m.cs_long = 1'b1;
      i.rext_bits = 4'h8;
      case (t)
        0: {i.vec_mandatory, i.rext_pfx, i.opsize_pfx, i.adsize_pfx} = 4'(k);
        1: begin
          m.mode = k[4] ? oss_pkg::OSS_MODE_REAL : k[3] ? oss_pkg::OSS_MODE_LONG
            : oss_pkg::OSS_MODE_PROT;
          {m.cs_long, m.cs_dflag, i.opsize_pfx, i.adsize_pfx} = {1'b0, 3'(k)};
        end
        2: begin
          i.ref_kind = oss_pkg::oss_ref_e'(3'(k[1:0]));
          i.seg_ovr = k[2];
          i.seg_ovr_sel = k[3] ? oss_pkg::OSS_SEG_AUXA : oss_pkg::OSS_SEG_EXTRA;
          {i.base_used, i.base_reg} = {1'b1, 2'h1, 2'(k >> 3)};
        end
        3: begin
          {i.is_arith, i.imm_present, i.arith_op} = {2'h3, 4'hC + 4'(k[1:0])};
          i.imm_value = k[2] ? 64'h0000_0001_0000_0000 : 64'h0000_0000_FFFF_FFFF;
        end
        default: {i.byte_reg, i.rext_pfx, i.byte_reg_num} = {1'b1, 5'(k)};
      endcase
      send(i, m);
    end
  endtask

  // side inputs change every cycle so the pass-through paths see fresh data
  always @(posedge clk_sys) begin
    #2;
    {ph, pl, far, sm, sr} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    sfm = ($urandom_range(1) == 1);
  end

  // take the oldest note whenever a result appears
  always @(negedge clk_sys) begin
    if (vld === 1'b1) check({res, la}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
  end

  initial begin
    oss_pkg::oss_instr_s i;
    oss_pkg::oss_modest_s m;
    void'($urandom(76515));
    foreach (bases[n]) bases[n] = {$urandom, $urandom};
    repeat (5) @(posedge clk_sys);
    #2;
    nrst = 1'b1;
    for (int t = 0; t < 6; t++) begin
      if (t < 5) directed(t);
      else for (int n = 0; n < 400; n++) begin
        i = {$urandom, $urandom, $urandom};
        i.valid = ($urandom_range(7) != 0);
        i.seg_ovr_sel = oss_pkg::oss_seg_e'(3'($urandom_range(5)));
        i.ref_kind = oss_pkg::oss_ref_e'(3'($urandom_range(3)));
        i.imm_present = i.is_arith;
        i.imm_value = {31'h0, 1'($urandom_range(1)), 32'($urandom)};
        m.mode = oss_pkg::oss_mode_e'(3'h1 << $urandom_range(2));
        {m.cs_long, m.cs_dflag} = 2'($urandom);
        send(i, m);
      end
      drain();
      $display("test %0d done", t);
    end
    // second reset in mid-run: valid and decode result outputs must return to their reset values
    #2;
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(75'({vld, res}), 75'h2B6);
    nrst = 1'b1;
    // traffic right after release shows nothing from before the reset lingers
    directed(0);
    drain();
    $display("test reset done");
    end_sim();
  end
endmodule // operand_size_segment_select_bench

bind oss_top oss_top_sva chk_u (.CLK_SYS_IN(CLK_SYS_IN), .NRST_IN(NRST_IN), .INSTR_IN(INSTR_IN),
  .MODE_IN(MODE_IN), .RESULT_OUT(RESULT_OUT), .PAIR_HIGH_IN(PAIR_HIGH_IN),
  .PAIR_LOW_IN(PAIR_LOW_IN), .PAIR_OUT(PAIR_OUT), .FAR_PTR_IN(FAR_PTR_IN),
  .FAR_OFS_OUT(FAR_OFS_OUT), .FAR_SEL_OUT(FAR_SEL_OUT), .SEL_FROM_MEM_IN(SEL_FROM_MEM_IN),
  .SEL_MEM_IN(SEL_MEM_IN), .SEL_REG_IN(SEL_REG_IN), .SEL_OUT(SEL_OUT));

// ==== tb/oss_top_sva.sv ====
// Purpose: port-level checks for the operand size and segment select decoder
// Assumes: one clock domain, asynchronous active-low reset
// Notes: every decode result is judged one cycle after the instruction is taken
`timescale 1ns/1ps
module oss_top_sva (
  input wire logic CLK_SYS_IN, // core clock
  input wire logic NRST_IN, // reset, active low
  input wire oss_pkg::oss_instr_s INSTR_IN, // instruction
  input wire oss_pkg::oss_modest_s MODE_IN, // mode state
  input wire oss_pkg::oss_result_s RESULT_OUT, // decode result
  input wire logic [63:0] PAIR_HIGH_IN, // first of pair
  input wire logic [63:0] PAIR_LOW_IN, // second of pair
  input wire logic [127:0] PAIR_OUT, // joined pair
  input wire logic [47:0] FAR_PTR_IN, // far pointer
  input wire logic [31:0] FAR_OFS_OUT, // far offset
  input wire logic [15:0] FAR_SEL_OUT, // far selector
  input wire logic SEL_FROM_MEM_IN, // selector source
  input wire logic [15:0] SEL_MEM_IN, // selector word
  input wire logic [15:0] SEL_REG_IN, // selector register
  input wire logic [15:0] SEL_OUT // chosen selector
);
  logic l64;
  logic wide;
  // the 64-bit table only holds with the long flag set, so gate the 64-bit size checks on it
  assign l64 = INSTR_IN.valid && MODE_IN.mode == oss_pkg::OSS_MODE_LONG && MODE_IN.cs_long;
  assign wide = INSTR_IN.rext_pfx && INSTR_IN.rext_bits[oss_pkg::REXT_W_BIT];
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!NRST_IN);
  long_default_a:
    assert property (l64 && !wide && !INSTR_IN.opsize_pfx && !INSTR_IN.adsize_pfx
      |=> RESULT_OUT.op_size == oss_pkg::OSS_SZ_32 && RESULT_OUT.ad_size == oss_pkg::OSS_SZ_64)
    else $error("wrong default sizes");
  no_addr16_a:
    assert property (l64 |=> RESULT_OUT.ad_size != oss_pkg::OSS_SZ_16) else $error("16-bit addr");
  wide_op_a:
    assert property (l64 && wide |=> RESULT_OUT.op_size == oss_pkg::OSS_SZ_64)
    else $error("wide bit ignored");
  narrow_op_a:
    assert property (l64 && !wide && INSTR_IN.opsize_pfx
      |=> RESULT_OUT.op_size == ($past(INSTR_IN.vec_mandatory) ? 2'h1 : 2'h0))
    else $error("operand override wrong");
  addr_ovr_a:
    assert property (l64 && INSTR_IN.adsize_pfx ##1 l64 && !INSTR_IN.adsize_pfx
      |=> RESULT_OUT.ad_size == oss_pkg::OSS_SZ_64) else $error("override lingers");
  compat_size_a:
    assert property (INSTR_IN.valid && MODE_IN.mode == oss_pkg::OSS_MODE_LONG
      && !MODE_IN.cs_long && !INSTR_IN.opsize_pfx && !INSTR_IN.adsize_pfx
      |=> RESULT_OUT.ad_size == {1'b0, $past(MODE_IN.cs_dflag)}) else $error("compat size");
  stack_base_a:
    assert property (INSTR_IN.valid && INSTR_IN.ref_kind == oss_pkg::OSS_REF_DATA
      && !INSTR_IN.seg_ovr && INSTR_IN.base_used && INSTR_IN.base_reg inside {4'h4, 4'h5}
      |=> RESULT_OUT.seg == oss_pkg::OSS_SEG_STACK) else $error("stack base segment");
  seg_ovr_a:
    assert property (INSTR_IN.valid && INSTR_IN.seg_ovr && INSTR_IN.ref_kind != oss_pkg::OSS_REF_NONE
      |=> RESULT_OUT.seg == ($past(INSTR_IN.ref_kind) == oss_pkg::OSS_REF_DATA
      ? $past(INSTR_IN.seg_ovr_sel) : $past(INSTR_IN.ref_kind) == oss_pkg::OSS_REF_FETCH
      ? oss_pkg::OSS_SEG_CODE : $past(INSTR_IN.ref_kind) == oss_pkg::OSS_REF_PUSHPOP
      ? oss_pkg::OSS_SEG_STACK : oss_pkg::OSS_SEG_EXTRA)) else $error("override handling");
  base_zero_a:
    assert property (l64 |=> RESULT_OUT.seg_base_zero == !RESULT_OUT.seg[2])
    else $error("base zeroing");
  byte_bad_a:
    assert property (INSTR_IN.valid && INSTR_IN.byte_reg && !INSTR_IN.rext_pfx
      && INSTR_IN.byte_reg_num[3] |=> !RESULT_OUT.byte_reg_ok) else $error("byte reg legal");
  pair_order_a:
    assert property (1'b1 |=> PAIR_OUT == {$past(PAIR_HIGH_IN), $past(PAIR_LOW_IN)})
    else $error("pair order");
  far_split_a:
    assert property (1'b1 |=> FAR_OFS_OUT == $past(FAR_PTR_IN[31:0])
      && FAR_SEL_OUT == $past(FAR_PTR_IN[47:32])) else $error("far pointer split");
  sel_src_a:
    assert property (SEL_FROM_MEM_IN ##1 !SEL_FROM_MEM_IN |-> SEL_OUT == $past(SEL_MEM_IN)
      ##1 SEL_OUT == $past(SEL_REG_IN)) else $error("selector source");
endmodule // oss_top_sva
